// ---- design/core_pkg.sv ----
// constants, state record and opcode length/timing decode for the core
package core_pkg;

  // ===========================================================================
  // data space locations
  localparam logic [7:0] ACC_ADDR = 8'hff;
  localparam logic [7:0] X_ADDR = 8'h80;
  localparam logic [7:0] Y_ADDR = 8'h81;
  localparam logic [5:0] SD_BASE = 6'h20;

  // ===========================================================================
  // low opcode nibble of the odd-numbered groups (even nibbles: flag branches)
  localparam logic [3:0] LO_CALL = 4'h1;
  localparam logic [3:0] LO_BTST = 4'h3;
  localparam logic [3:0] LO_SHORT = 4'h5;
  localparam logic [3:0] LO_IND = 4'h7;
  localparam logic [3:0] LO_JUMP = 4'h9;
  localparam logic [3:0] LO_BSET = 4'hb;
  localparam logic [3:0] LO_INH = 4'hd;
  localparam logic [3:0] LO_DIRIMM = 4'hf;

  // operation field op[7:5] of indirect, direct and immediate groups
  localparam logic [2:0] F_LDA = 3'd0;
  localparam logic [2:0] F_STA = 3'd1;
  localparam logic [2:0] F_CMP = 3'd2;
  localparam logic [2:0] F_ADD = 3'd3;
  localparam logic [2:0] F_INC = 3'd4;
  localparam logic [2:0] F_DEC = 3'd5;
  localparam logic [2:0] F_AND = 3'd6;
  localparam logic [2:0] F_SUB = 3'd7;
  // immediate reuse of fields 1, 4 and 5
  localparam logic [2:0] F_LDR = 3'd1;
  localparam logic [2:0] F_CLR = 3'd4;
  localparam logic [2:0] F_CLRA = 3'd5;

  // short-direct operation field op[5:4]
  localparam logic [1:0] S_INC = 2'd0;
  localparam logic [1:0] S_LDA = 2'd1;
  localparam logic [1:0] S_STA = 2'd2;
  localparam logic [1:0] S_DEC = 2'd3;

  // inherent operation field op[7:4]
  localparam logic [3:0] I_NOP = 4'h0;
  localparam logic [3:0] I_RET = 4'h1;
  localparam logic [3:0] I_INTERRUPT_EXIT = 4'h2;
  localparam logic [3:0] I_STOP = 4'h3;
  localparam logic [3:0] I_WAIT = 4'h4;
  localparam logic [3:0] I_COM = 4'h5;
  localparam logic [3:0] I_RLC = 4'h6;
  localparam logic [3:0] I_SLA = 4'h7;

  // ===========================================================================
  // byte counts, cycle counts, branch offsets
  localparam logic [1:0] LEN1 = 2'd1;
  localparam logic [1:0] LEN2 = 2'd2;
  localparam logic [1:0] LEN3 = 2'd3;
  localparam logic [2:0] CYC_SHORT = 3'd2;
  localparam logic [2:0] CYC_STD = 3'd4;
  localparam logic [2:0] CYC_BTST = 3'd5;
  localparam logic [11:0] REL_OFS = 12'h001;
  localparam logic [11:0] BT_OFS = 12'h002;

  typedef struct packed {
    logic [11:0] pc;
    logic [11:0] instAddr;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [2:0] cyc;
    logic [7:0] acc;
    logic z;
    logic c;
    logic [2:0] sp;
    logic waiting;
    logic stopped;
    logic done;
  } core_state_s;

  function automatic logic [1:0] opLen(input logic [7:0] op);
    logic [1:0] l;
    l = LEN1;
    unique case (op[3:0])
      LO_CALL, LO_JUMP, LO_BSET: l = LEN2;
      LO_BTST: l = LEN3;
      LO_DIRIMM:
        if (!op[4] && (op[7:5] == F_LDR || op[7:5] == F_CLR))
          l = LEN3;
        else
          l = LEN2;
      LO_INH:
        if (op[7:4] == I_SLA)
          l = LEN2;
      default: l = LEN1;
    endcase
    return l;
  endfunction : opLen

  function automatic logic [2:0] opCycles(input logic [7:0] op);
    logic [2:0] k;
    k = CYC_STD;
    if (!op[0] || op[3:0] == LO_INH && op[7:4] <= I_WAIT)
      k = CYC_SHORT;
    else if (op[3:0] == LO_BTST)
      k = CYC_BTST;
    return k;
  endfunction : opCycles

endpackage : core_pkg

// ---- design/core_exec.sv ----
// eight-bit core: fetch, decode and execute of the full instruction set
`timescale 1ns/1ps
`default_nettype none

module core_exec #(
  parameter logic [11:0] RESET_PC = 12'h000,
  parameter int STACK_DEPTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // program memory
  output logic [11:0] progAddr,
  input wire logic [7:0] progData,
  // mode control
  input wire logic wdgEnable,
  input wire logic wakeUp,
  // observed state
  output logic [7:0] accOut,
  output logic zeroFlag,
  output logic carryFlag,
  output logic waitMode,
  output logic stopMode,
  output logic instrDone
);

  // ===========================================================================
  // storage
  core_pkg::core_state_s s_reg;
  core_pkg::core_state_s s_next;
  logic [7:0] ram [256];
  logic [13:0] stk [STACK_DEPTH];

  logic ramWe;
  logic [7:0] ramAddr;
  logic [7:0] ramWd;
  logic stkWe;
  logic [2:0] stkIdx;
  logic [7:0] opc;
  logic [7:0] ptr;
  logic [7:0] oaddr;
  logic [7:0] oval;
  logic [7:0] src;
  logic [7:0] wv;
  logic [8:0] sum;
  logic [8:0] diff;
  logic [2:0] cycs;
  logic isImm;
  logic doWr;
  logic take;
  logic bitv;
  logic [2:0] popIdx;

  // ===========================================================================
  // operand selection
  always_comb
  begin
    opc = (s_reg.cyc == 3'h0) ? progData : s_reg.op;
    cycs = core_pkg::opCycles(opc);
    ptr = ram[s_reg.op[4] ? core_pkg::Y_ADDR : core_pkg::X_ADDR];
    isImm = s_reg.op[3:0] == core_pkg::LO_DIRIMM && !s_reg.op[4];
    unique case (s_reg.op[3:0])
      core_pkg::LO_IND: oaddr = ptr;
      core_pkg::LO_SHORT: oaddr = {core_pkg::SD_BASE, s_reg.op[7:6]};
      default: oaddr = s_reg.b1;
    endcase
    oval = (oaddr == core_pkg::ACC_ADDR) ? s_reg.acc : ram[oaddr];
    src = isImm ? s_reg.b1 : oval;
    sum = {1'b0, s_reg.acc} + {1'b0, src};
    diff = {1'b0, s_reg.acc} - {1'b0, src};
    bitv = oval[s_reg.op[7:5]];
    popIdx = (s_reg.sp == 3'h0) ? 3'h0 : s_reg.sp - 3'h1;
    unique case (s_reg.op[2:1])
      2'd0: take = !s_reg.z;
      2'd1: take = !s_reg.c;
      2'd2: take = s_reg.z;
      default: take = s_reg.c;
    endcase
  end

  // ===========================================================================
  // sequencing and execution
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    ramWe = 1'b0;
    ramAddr = oaddr;
    ramWd = 8'h00;
    stkWe = 1'b0;
    stkIdx = (s_reg.sp == 3'(STACK_DEPTH)) ? 3'(STACK_DEPTH - 1) : s_reg.sp;
    doWr = 1'b0;
    wv = 8'h00;
    if (s_reg.waiting || s_reg.stopped)
    begin
      if (wakeUp)
      begin
        s_next.waiting = 1'b0;
        s_next.stopped = 1'b0;
      end
    end
    else
    begin
      if (s_reg.cyc == 3'h0)
      begin
        s_next.op = progData;
        s_next.instAddr = s_reg.pc;
        s_next.pc = s_reg.pc + 12'h001;
      end
      else if (s_reg.cyc == 3'h1 && core_pkg::opLen(opc) >= core_pkg::LEN2)
      begin
        s_next.b1 = progData;
        s_next.pc = s_reg.pc + 12'h001;
      end
      else if (s_reg.cyc == 3'h2 && core_pkg::opLen(opc) == core_pkg::LEN3)
      begin
        s_next.b2 = progData;
        s_next.pc = s_reg.pc + 12'h001;
      end
      s_next.cyc = s_reg.cyc + 3'h1;
      if (s_reg.cyc != 3'h0 && s_reg.cyc == cycs - 3'h1)
      begin
        s_next.cyc = 3'h0;
        s_next.done = 1'b1;
        if (!s_reg.op[0])
        begin
          if (take)
            s_next.pc = s_reg.instAddr + core_pkg::REL_OFS
              + {{7{s_reg.op[7]}}, s_reg.op[7:3]};
        end
        else
        begin
          unique case (s_reg.op[3:0])
            core_pkg::LO_CALL, core_pkg::LO_JUMP:
            begin
              if (s_reg.op[3:0] == core_pkg::LO_CALL)
              begin
                stkWe = 1'b1;
                if (s_reg.sp != 3'(STACK_DEPTH))
                  s_next.sp = s_reg.sp + 3'h1;
              end
              s_next.pc = {s_reg.op[7:4], s_reg.b1};
            end
            core_pkg::LO_BTST:
            begin
              s_next.c = bitv;
              if (bitv == s_reg.op[4])
                s_next.pc = s_reg.instAddr + core_pkg::BT_OFS
                  + {{4{s_reg.b2[7]}}, s_reg.b2};
            end
            core_pkg::LO_BSET:
            begin
              wv = oval;
              wv[s_reg.op[7:5]] = s_reg.op[4];
              doWr = 1'b1;
            end
            core_pkg::LO_SHORT:
            begin
              unique case (s_reg.op[5:4])
                core_pkg::S_INC: wv = oval + 8'h01;
                core_pkg::S_DEC: wv = oval - 8'h01;
                core_pkg::S_LDA: s_next.acc = oval;
                default: wv = s_reg.acc;
              endcase
              doWr = s_reg.op[5:4] != core_pkg::S_LDA;
              s_next.z = (s_reg.op[5:4] == core_pkg::S_LDA) ? oval == 8'h00
                : wv == 8'h00;
            end
            core_pkg::LO_INH:
            begin
              unique case (s_reg.op[7:4])
                core_pkg::I_RET: s_next.pc = stk[popIdx][11:0];
                core_pkg::I_INTERRUPT_EXIT:
                  {s_next.z, s_next.c, s_next.pc} = stk[popIdx];
                core_pkg::I_STOP:
                begin
                  s_next.waiting = wdgEnable;
                  s_next.stopped = !wdgEnable;
                end
                core_pkg::I_WAIT: s_next.waiting = 1'b1;
                core_pkg::I_COM: {s_next.c, s_next.acc} = {s_reg.acc[7], ~s_reg.acc};
                core_pkg::I_RLC: {s_next.c, s_next.acc} = {s_reg.acc, s_reg.c};
                core_pkg::I_SLA: {s_next.c, s_next.acc} = {s_reg.acc, 1'b0};
                default: s_next.acc = s_reg.acc;
              endcase
              if (s_reg.op[7:4] == core_pkg::I_RET
                || s_reg.op[7:4] == core_pkg::I_INTERRUPT_EXIT)
                s_next.sp = popIdx;
              if (s_reg.op[7:4] >= core_pkg::I_COM
                && s_reg.op[7:4] <= core_pkg::I_SLA)
                s_next.z = s_next.acc == 8'h00;
            end
            default:
            begin
              // indirect, direct and immediate groups
              unique case (s_reg.op[7:5])
                core_pkg::F_LDA:
                begin
                  s_next.acc = src;
                  s_next.z = src == 8'h00;
                end
                core_pkg::F_STA:
                begin
                  wv = isImm ? s_reg.b2 : s_reg.acc;
                  doWr = 1'b1;
                  if (!isImm)
                    s_next.z = s_reg.acc == 8'h00;
                end
                core_pkg::F_CMP:
                begin
                  s_next.z = diff[7:0] == 8'h00;
                  s_next.c = diff[8];
                end
                core_pkg::F_ADD:
                begin
                  s_next.acc = sum[7:0];
                  s_next.z = sum[7:0] == 8'h00;
                  s_next.c = sum[8];
                end
                core_pkg::F_INC:
                begin
                  wv = isImm ? 8'h00 : oval + 8'h01;
                  doWr = 1'b1;
                  if (!isImm)
                    s_next.z = wv == 8'h00;
                end
                core_pkg::F_DEC:
                begin
                  if (isImm)
                    {s_next.z, s_next.c, s_next.acc} = {2'b10, 8'h00};
                  else
                  begin
                    wv = oval - 8'h01;
                    doWr = 1'b1;
                    s_next.z = wv == 8'h00;
                  end
                end
                core_pkg::F_AND:
                begin
                  s_next.acc = s_reg.acc & src;
                  s_next.z = (s_reg.acc & src) == 8'h00;
                  s_next.c = 1'b0;
                end
                default:
                begin
                  s_next.acc = diff[7:0];
                  s_next.z = diff[7:0] == 8'h00;
                  s_next.c = diff[8];
                end
              endcase
            end
          endcase
        end
        if (doWr)
        begin
          if (oaddr == core_pkg::ACC_ADDR)
            s_next.acc = wv;
          else
          begin
            ramWe = 1'b1;
            ramWd = wv;
          end
        end
      end
    end
  end

  // ===========================================================================
  // registers and memories
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.pc <= RESET_PC;
    end
    else
      s_reg <= s_next;
  end

  always_ff @(posedge clk)
  begin
    if (ramWe)
      ram[ramAddr] <= ramWd;
    if (stkWe)
      stk[stkIdx] <= {s_reg.z, s_reg.c, s_reg.pc};
  end

  assign progAddr = s_reg.pc;
  assign accOut = s_reg.acc;
  assign zeroFlag = s_reg.z;
  assign carryFlag = s_reg.c;
  assign waitMode = s_reg.waiting;
  assign stopMode = s_reg.stopped;
  assign instrDone = s_reg.done;

endmodule : core_exec

`default_nettype wire

// ---- test/core_exec_checker.sv ----
// port-level assertion checker for the core
`timescale 1ns/1ps
`default_nettype none
module core_exec_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // program memory
  input wire logic [11:0] progAddr,
  input wire logic [7:0] progData,
  // mode control
  input wire logic wdgEnable,
  input wire logic wakeUp,
  // observed state
  input wire logic [7:0] accOut,
  input wire logic zeroFlag,
  input wire logic carryFlag,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic instrDone
);
  // ====
  // opcode and first operand of the instruction now running
  logic start;
  logic startDly;
  logic [7:0] opq;
  logic [7:0] b1q;
  assign start = instrDone && !waitMode && !stopMode;
  always_ff @(posedge clk)
  begin
    startDly <= start;
    if (start)
      opq <= progData;
    if (startDly)
      b1q <= progData;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ADD: assert property (start && progData == 8'h6f |=> !instrDone [*3]
    ##1 (instrDone && progAddr == $past(progAddr, 4) + 12'h002))
    else $error("add length or timing wrong");
  AST_BR: assert property (start && !progData[0] |=>
    !instrDone ##1 instrDone) else $error("flag branch timing wrong");
  AST_BT: assert property (start && progData[3:0] == 4'h3 |=>
    !instrDone [*4] ##1 (instrDone && zeroFlag == $past(zeroFlag, 5)))
    else $error("bit test timing or zero flag wrong");
  AST_SD: assert property (start && progData == 8'h25 |-> ##4
    progAddr == $past(progAddr, 4) + 12'h001
    && carryFlag == $past(carryFlag, 4)) else $error("short move wrong");
  AST_LDR: assert property (start && progData == 8'h2f |-> ##4
    progAddr == $past(progAddr, 4) + 12'h003 && carryFlag ==
    $past(carryFlag, 4) && zeroFlag == $past(zeroFlag, 4))
    else $error("register load wrong");
  AST_INC: assert property (start && progData == 8'h05 |-> ##4
    instrDone && carryFlag == $past(carryFlag, 4))
    else $error("count up changed carry");
  AST_JUMP: assert property (start && (progData[3:0] == 4'h9
    || progData[3:0] == 4'h1) |-> ##4 progAddr == {opq[7:4], b1q})
    else $error("jump target wrong");
  AST_STOP: assert property (start && progData == 8'h3d && wdgEnable
    |-> ##2 waitMode && !stopMode) else $error("stop not turned to wait");
  AST_BSET: assert property (start && progData[3:0] == 4'hb |-> ##4
    instrDone && progAddr == $past(progAddr, 4) + 12'h002
    && zeroFlag == $past(zeroFlag, 4) && carryFlag == $past(carryFlag, 4))
    else $error("bit set or clear wrong");
  AST_WAIT: assert property (waitMode && !wakeUp |=>
    waitMode && $stable(progAddr)) else $error("wait left early");
endmodule : core_exec_checker
bind core_exec core_exec_checker chk (.*);
`default_nettype wire

// ---- test/eight_bit_core_instruction_set_tb.sv ----
// self-checking bench for the core
`timescale 1ns/1ps
`default_nettype none
module eight_bit_core_instruction_set_tb;
  logic clk;
  logic resetn;
  logic [11:0] progAddr;
  logic [7:0] progData;
  logic wdgEnable;
  logic wakeUp;
  logic [7:0] accOut;
  logic zeroFlag;
  logic carryFlag;
  logic waitMode;
  logic stopMode;
  logic instrDone;
  logic [7:0] rom [0:4095];
  int mismatches = 0;
  int checked = 0;
  assign progData = rom[progAddr];
  core_exec dut (.clk(clk), .resetn(resetn), .progAddr(progAddr),
    .progData(progData), .wdgEnable(wdgEnable), .wakeUp(wakeUp),
    .accOut(accOut), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
    .waitMode(waitMode), .stopMode(stopMode), .instrDone(instrDone));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====
  // shared tasks
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic put(input logic [11:0] a, input logic [7:0] p[$]);
    foreach (p[i])
      rom[a + 12'(i)] = p[i];
  endtask : put
  task automatic boot();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
  endtask : boot
  // waits for the next completed instruction and compares the state
  task automatic step(input logic [11:0] pc, input logic [7:0] a,
    input logic z, input logic c);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (instrDone !== 1'b1 && n < 20);
    check({progAddr, accOut, zeroFlag, carryFlag}, {pc, a, z, c});
  endtask : step
  task automatic wake(input logic wdg);
    repeat (3) @(posedge clk);
    wakeUp <= 1'b1;
    wdgEnable <= wdg;
    @(posedge clk);
    wakeUp <= 1'b0;
  endtask : wake
  // ====
  // scenarios
  task automatic s_alu();
    put(12'h000, '{8'h0f, 8'hff, 8'h6f, 8'h01, 8'h2f, 8'h84, 8'h07, 8'h1f,
      8'h84, 8'hef, 8'h08, 8'h25, 8'h05, 8'h15, 8'h8f, 8'h84, 8'h00, 8'h1f,
      8'h84, 8'haf, 8'h00, 8'h5d, 8'h6d, 8'h7d, 8'h00});
    boot();
    step(12'h002, 8'hff, 1'b0, 1'b0);
    step(12'h004, 8'h00, 1'b1, 1'b1);
    step(12'h007, 8'h00, 1'b1, 1'b1);
    step(12'h009, 8'h07, 1'b0, 1'b1);
    step(12'h00b, 8'hff, 1'b0, 1'b1);
    step(12'h00c, 8'hff, 1'b0, 1'b1);
    step(12'h00d, 8'hff, 1'b1, 1'b1);
    step(12'h00e, 8'h00, 1'b1, 1'b1);
    step(12'h011, 8'h00, 1'b1, 1'b1);
    step(12'h013, 8'h00, 1'b1, 1'b1);
    step(12'h015, 8'h00, 1'b1, 1'b0);
    step(12'h016, 8'hff, 1'b0, 1'b0);
    step(12'h017, 8'hfe, 1'b0, 1'b1);
    step(12'h019, 8'hfc, 1'b0, 1'b1);
  endtask : s_alu
  task automatic s_flow();
    put(12'h000, '{8'h0f, 8'h00, 8'h10, 8'h7c, 8'h16, 8'h03, 8'hff, 8'h7f});
    put(12'h00a, '{8'h11, 8'hc5, 8'hf9, 8'h20});
    put(12'h013, '{8'h82});
    put(12'h086, '{8'h0f, 8'h80, 8'hf3, 8'hff, 8'h80});
    put(12'h1c5, '{8'haf, 8'h00, 8'h2d});
    put(12'hf20, '{8'h0d, 8'h3d, 8'h3d, 8'h4d});
    boot();
    step(12'h002, 8'h00, 1'b1, 1'b0);
    step(12'h003, 8'h00, 1'b1, 1'b0);
    step(12'h013, 8'h00, 1'b1, 1'b0);
    step(12'h004, 8'h00, 1'b1, 1'b0);
    step(12'h005, 8'h00, 1'b1, 1'b0);
    step(12'h086, 8'h00, 1'b1, 1'b0);
    step(12'h088, 8'h80, 1'b0, 1'b0);
    step(12'h00a, 8'h80, 1'b0, 1'b1);
    step(12'h1c5, 8'h80, 1'b0, 1'b1);
    step(12'h1c7, 8'h00, 1'b1, 1'b0);
    step(12'h00c, 8'h00, 1'b0, 1'b1);
    step(12'hf20, 8'h00, 1'b0, 1'b1);
    step(12'hf21, 8'h00, 1'b0, 1'b1);
    step(12'hf22, 8'h00, 1'b0, 1'b1);
    check({20'h0, waitMode, stopMode}, 22'h2);
    wake(1'b0);
    step(12'hf23, 8'h00, 1'b0, 1'b1);
    check({20'h0, waitMode, stopMode}, 22'h1);
    wake(1'b0);
    step(12'hf24, 8'h00, 1'b0, 1'b1);
    check({20'h0, waitMode, stopMode}, 22'h2);
    wake(1'b0);
  endtask : s_flow
  task automatic s_bits();
    put(12'h000, '{8'h0f, 8'h81, 8'h2f, 8'h82, 8'hf0, 8'h3b, 8'h82, 8'heb,
      8'h82, 8'h1f, 8'h82, 8'h2f, 8'h80, 8'h82, 8'h4f, 8'hff, 8'hc7, 8'h47,
      8'hb7, 8'h35, 8'h15, 8'h11, 8'h20});
    put(12'h120, '{8'h4f, 8'hff, 8'h1d});
    boot();
    step(12'h002, 8'h81, 1'b0, 1'b0);
    step(12'h005, 8'h81, 1'b0, 1'b0);
    step(12'h007, 8'h81, 1'b0, 1'b0);
    step(12'h009, 8'h81, 1'b0, 1'b0);
    step(12'h00b, 8'h72, 1'b0, 1'b0);
    step(12'h00e, 8'h72, 1'b0, 1'b0);
    step(12'h010, 8'h72, 1'b0, 1'b1);
    step(12'h011, 8'h72, 1'b0, 1'b0);
    step(12'h012, 8'h72, 1'b1, 1'b0);
    step(12'h013, 8'h72, 1'b0, 1'b0);
    step(12'h014, 8'h72, 1'b0, 1'b0);
    step(12'h015, 8'h81, 1'b0, 1'b0);
    step(12'h120, 8'h81, 1'b0, 1'b0);
    step(12'h122, 8'h81, 1'b0, 1'b1);
    step(12'h017, 8'h81, 1'b0, 1'b1);
  endtask : s_bits
  // ====
  // main sequence and watchdog
  initial
  begin
    resetn = 1'b0;
    wdgEnable = 1'b1;
    wakeUp = 1'b0;
    foreach (rom[i])
      rom[i] = 8'h0d;
    s_alu();
    s_flow();
    s_bits();
    end_sim();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : eight_bit_core_instruction_set_tb
`default_nettype wire
